// File: verilog/ucds_consts.vh
// Constants for the charger detection sequencer: register map, PHY register
// addresses and values, field positions. Included by the sequencer top.
//
// Operation
// - Resistance check: wait ID grounded, ID pull-up on, start conversion, wait done, read code.
// - In synchronous mode session valid is taken from the received RXCMD byte.
// - In low power mode the interrupt on ULPI data line 3 is watched.
// - On that interrupt, wake the PHY, then read its registers for the cause.
// - Short test preparation writes 49h to function control at address 04h.
// - DP charger pull-up is connected by setting bit 4 at address 3Ah.
// - DM charger pull-up is connected by writing 20h at address 3Ah.
// - In synchronous mode line state comes from RXCMD or the debug register.
// - In low power mode line state is sampled from data lines 0 and 1.
// - Order: session valid, non-driving FS, DP pull-up, DM pull-up, evaluate.
// - Line state SE1 reports a charger.
// - Line state SE0 reports a host.
`ifndef UCDS_CONSTS_VH
`define UCDS_CONSTS_VH

// ----------------------------------------------------------------
// Wishbone register map (byte addresses)
// ----------------------------------------------------------------
`define UCDS_A_CTRL 8'h00
`define UCDS_A_STATUS 8'h04
`define UCDS_A_IRQ_STAT 8'h08
`define UCDS_A_IRQ_CLR 8'h0c
`define UCDS_A_IRQ_EN 8'h10

// Control bits
`define UCDS_CTRL_START 0
`define UCDS_CTRL_RID_EN 1
`define UCDS_CTRL_LOWPWR 2

// Result codes
`define UCDS_RES_NONE 2'h0
`define UCDS_RES_CHARGER 2'h1
`define UCDS_RES_HOST 2'h2
`define UCDS_RES_UNDET 2'h3

// Interrupt bits
`define UCDS_IRQ_DONE 0
`define UCDS_IRQ_CHARGER 1
`define UCDS_IRQ_HOST 2
`define UCDS_IRQ_UNDET 3

// ----------------------------------------------------------------
// PHY registers and values
// ----------------------------------------------------------------
`define UCDS_TX_WR 2'h2
`define UCDS_TX_RD 2'h3
`define UCDS_PHY_FUNC 6'h04
`define UCDS_FUNC_FS_NODRV 8'h49
`define UCDS_PHY_OTG_SET 6'h0b
`define UCDS_OTG_IDPU 8'h01
`define UCDS_PHY_IRQ_STAT 6'h13
`define UCDS_BIT_SESS 2
`define UCDS_BIT_ID_GROUNDED_FLAG 4
`define UCDS_PHY_DEBUG 6'h15
`define UCDS_PHY_RID 6'h36
`define UCDS_PHY_RID_SET 6'h37
`define UCDS_RID_START 8'h10
`define UCDS_BIT_RID_DONE 3
`define UCDS_PHY_PWR_SET 6'h3a
`define UCDS_PHY_PWR_CLR 6'h3b
`define UCDS_PWR_DP 8'h10
`define UCDS_PWR_DM 8'h20
`define UCDS_RXCMD_SESS 3
`define UCDS_LS_SE0 2'h0
`define UCDS_LS_SE1 2'h3

`endif

// File: verilog/ucds_sync.v
// Two-stage synchroniser for a group of pins.
// Assumes each bit is a level; bits of one group may skew by one clock.
`timescale 1ns/100ps
`default_nettype none

module ucds_sync #(
	parameter W = 1
) (
	// Clock and reset
	input wire clk_sys,
	input wire arst_n,
	// Pins in, synchronised levels out
	input wire [W-1:0] d_in,
	output wire [W-1:0] d_out
);

	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;

	// ----------------------------------------------------------------
	// Double register; only the second stage is read outside
	// ----------------------------------------------------------------
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			meta_q <= {W{1'b0}};
			sync_q <= {W{1'b0}};
		end else begin
			meta_q <= d_in;
			sync_q <= meta_q;
		end
	end

	assign d_out = sync_q;

endmodule
`default_nettype wire

// File: verilog/ucds_top.v
// Charger detection sequencer: a ULPI link that drives the PHY register
// interface to tell a charger from a host. Software controls it over
// classic Wishbone. Assumes the ULPI clock is slow enough (8 system
// clocks or more) to be sampled and edge-detected on clk_sys.
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "ucds_consts.vh"

module ucds_top (
	// Clock and reset
	input wire clk_sys,
	input wire arst_n,
	// Wishbone slave
	input wire [7:0] wb_adr_i,
	input wire [31:0] wb_dat_i,
	input wire [3:0] wb_sel_i,
	input wire wb_we_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// Interrupt
	output reg irq,
	// ULPI link
	input wire ulpi_clk,
	input wire ulpi_dir,
	input wire ulpi_nxt,
	input wire [7:0] ulpi_data_i,
	output reg [7:0] ulpi_data_o,
	output reg ulpi_data_oe,
	output reg ulpi_stp
);

	// ----------------------------------------------------------------
	// Sequencer and transfer engine states
	// ----------------------------------------------------------------
	localparam [3:0] S_IDLE = 4'h0, S_RID_POLL = 4'h1, S_RID_PU = 4'h2, S_RID_GO = 4'h3;
	localparam [3:0] S_RID_WAIT = 4'h4, S_SV_WAIT = 4'h5, S_WAKE = 4'h6, S_SV_READ = 4'h7;
	localparam [3:0] S_SAVE = 4'h8, S_FS = 4'h9, S_PU_DP = 4'ha, S_PU_DM = 4'hb;
	localparam [3:0] S_LINE = 4'hc, S_CLR_PU = 4'hd, S_RESTORE = 4'he, S_DONE = 4'hf;
	localparam [2:0] E_IDLE = 3'h0, E_WCMD = 3'h1, E_WDAT = 3'h2, E_WSTP = 3'h3;
	localparam [2:0] E_RCMD = 3'h4, E_RTA = 3'h5, E_RDAT = 3'h6, E_REND = 3'h7;

	wire [10:0] pin_s;
	wire uclk_s;
	wire dir_s;
	wire nxt_s;
	wire [7:0] dat_s;
	wire ue;
	reg uclk_d_q;
	reg [3:0] st_q;
	reg [2:0] es_q;
	reg x_done_q;
	reg [7:0] rd_q;
	reg [7:0] rx_q;
	reg dir_e_q;
	reg nsync_q;
	reg busy_q;
	reg [1:0] res_q;
	reg [2:0] rcode_q;
	reg rid_ok_q;
	reg [1:0] line_q;
	reg [1:0] live_ls_q;
	reg [7:0] saved_q;
	reg [3:0] ev_q;
	reg [2:0] ctrl_q;
	reg [3:0] irq_stat_q;
	reg [3:0] irq_en_q;
	reg start_q;
	reg t_go;
	reg t_rd;
	reg [5:0] t_addr;
	reg [7:0] t_wdat;
	wire wb_req;
	wire wb_wr;

	// ----------------------------------------------------------------
	// Pin synchronisation and ULPI clock edge
	// ----------------------------------------------------------------
	ucds_sync #(
		.W(11)
	) u_sync (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.d_in({ulpi_clk, ulpi_dir, ulpi_nxt, ulpi_data_i}),
		.d_out(pin_s)
	);

	assign uclk_s = pin_s[10];
	assign dir_s = pin_s[9];
	assign nxt_s = pin_s[8];
	assign dat_s = pin_s[7:0];
	assign ue = uclk_s & ~uclk_d_q;

	// ----------------------------------------------------------------
	// Register transfer selected by the sequencer state
	// ----------------------------------------------------------------
	always @* begin
		t_go = 1'b1;
		t_rd = 1'b0;
		t_addr = 6'h00;
		t_wdat = 8'h00;
		case (st_q)
			S_RID_POLL: begin
				t_rd = 1'b1;
				t_addr = `UCDS_PHY_IRQ_STAT;
			end
			S_RID_PU: begin
				t_addr = `UCDS_PHY_OTG_SET;
				t_wdat = `UCDS_OTG_IDPU;
			end
			S_RID_GO: begin
				t_addr = `UCDS_PHY_RID_SET;
				t_wdat = `UCDS_RID_START;
			end
			S_RID_WAIT: begin
				t_rd = 1'b1;
				t_addr = `UCDS_PHY_RID;
			end
			S_SV_READ: begin
				t_rd = 1'b1;
				t_addr = `UCDS_PHY_IRQ_STAT;
			end
			S_SAVE: begin
				t_rd = 1'b1;
				t_addr = `UCDS_PHY_FUNC;
			end
			S_FS: begin
				t_addr = `UCDS_PHY_FUNC;
				t_wdat = `UCDS_FUNC_FS_NODRV;
			end
			S_PU_DP: begin
				t_addr = `UCDS_PHY_PWR_SET;
				t_wdat = `UCDS_PWR_DP;
			end
			S_PU_DM: begin
				t_addr = `UCDS_PHY_PWR_SET;
				t_wdat = `UCDS_PWR_DM;
			end
			S_LINE: begin
				t_rd = 1'b1;
				t_addr = `UCDS_PHY_DEBUG;
			end
			S_CLR_PU: begin
				t_addr = `UCDS_PHY_PWR_CLR;
				t_wdat = `UCDS_PWR_DP | `UCDS_PWR_DM;
			end
			S_RESTORE: begin
				t_addr = `UCDS_PHY_FUNC;
				t_wdat = saved_q;
			end
			default: t_go = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// ULPI transfer engine; drives data and stp only on sampled ULPI clock edges
	// ----------------------------------------------------------------
	// A transfer cut short by dir rising is dropped and retried from idle,
	// since the PHY owns the bus first.
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			uclk_d_q <= 1'b0;
			es_q <= E_IDLE;
			x_done_q <= 1'b0;
			rd_q <= 8'h00;
			rx_q <= 8'h00;
			dir_e_q <= 1'b0;
			live_ls_q <= 2'h0;
			ulpi_data_o <= 8'h00;
			ulpi_data_oe <= 1'b0;
			ulpi_stp <= 1'b0;
		end else begin
			uclk_d_q <= uclk_s;
			x_done_q <= 1'b0;
			ulpi_data_oe <= ~dir_s; // Release the bus as soon as the PHY turns it
			if (ue) begin
				dir_e_q <= dir_s;
				if (nsync_q && dir_s) begin
					live_ls_q <= dat_s[1:0];
				end else if (dir_s && dir_e_q && !nxt_s && es_q != E_RDAT) begin
					rx_q <= dat_s;
					live_ls_q <= dat_s[1:0];
				end
				if (st_q == S_WAKE) begin
					ulpi_stp <= dir_s;
				end
				case (es_q)
					E_IDLE: begin
						if (t_go && !x_done_q && !dir_s) begin
							ulpi_data_o <= {(t_rd ? `UCDS_TX_RD : `UCDS_TX_WR), t_addr};
							es_q <= t_rd ? E_RCMD : E_WCMD;
						end
					end
					E_WCMD, E_WDAT: begin
						if (dir_s) begin
							ulpi_data_o <= 8'h00;
							es_q <= E_IDLE;
						end else if (nxt_s && es_q == E_WCMD) begin
							ulpi_data_o <= t_wdat;
							es_q <= E_WDAT;
						end else if (nxt_s) begin
							ulpi_data_o <= 8'h00;
							ulpi_stp <= 1'b1;
							es_q <= E_WSTP;
						end
					end
					E_WSTP: begin
						ulpi_stp <= 1'b0;
						x_done_q <= 1'b1;
						es_q <= E_IDLE;
					end
					E_RCMD: begin
						if (dir_s) begin
							ulpi_data_o <= 8'h00;
							es_q <= E_IDLE;
						end else if (nxt_s) begin
							ulpi_data_o <= 8'h00;
							es_q <= E_RTA;
						end
					end
					E_RTA: begin
						if (dir_s) begin
							es_q <= E_RDAT;
						end
					end
					E_RDAT: begin
						rd_q <= dat_s;
						es_q <= E_REND;
					end
					E_REND: begin
						if (!dir_s) begin
							x_done_q <= 1'b1;
							es_q <= E_IDLE;
						end
					end
					default: es_q <= E_IDLE;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Detection sequencer
	// ----------------------------------------------------------------
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= S_IDLE;
			nsync_q <= 1'b0;
			busy_q <= 1'b0;
			res_q <= `UCDS_RES_NONE;
			rcode_q <= 3'h0;
			rid_ok_q <= 1'b0;
			line_q <= 2'h0;
			saved_q <= 8'h00;
			ev_q <= 4'h0;
		end else begin
			ev_q <= 4'h0;
			case (st_q)
				S_IDLE: begin
					if (start_q) begin
						busy_q <= 1'b1;
						nsync_q <= ctrl_q[`UCDS_CTRL_LOWPWR];
						res_q <= `UCDS_RES_NONE;
						rid_ok_q <= 1'b0;
						st_q <= ctrl_q[`UCDS_CTRL_RID_EN] ? S_RID_POLL : S_SV_WAIT;
					end
				end
				S_RID_POLL: begin
					if (x_done_q && rd_q[`UCDS_BIT_ID_GROUNDED_FLAG]) begin
						st_q <= S_RID_PU;
					end
				end
				S_RID_PU: begin
					if (x_done_q) begin
						st_q <= S_RID_GO;
					end
				end
				S_RID_GO: begin
					if (x_done_q) begin
						st_q <= S_RID_WAIT;
					end
				end
				S_RID_WAIT: begin
					if (x_done_q && rd_q[`UCDS_BIT_RID_DONE]) begin
						rcode_q <= rd_q[2:0];
						rid_ok_q <= 1'b1;
						st_q <= S_SV_WAIT;
					end
				end
				S_SV_WAIT: begin
					if (nsync_q) begin
						if (ue && dir_s && dat_s[3]) begin
							st_q <= S_WAKE;
						end
					end else if (rx_q[`UCDS_RXCMD_SESS]) begin
						st_q <= S_SAVE;
					end
				end
				S_WAKE: begin
					if (ue && !dir_s) begin
						nsync_q <= 1'b0;
						st_q <= S_SV_READ;
					end
				end
				S_SV_READ: begin
					if (x_done_q) begin
						st_q <= rd_q[`UCDS_BIT_SESS] ? S_SAVE : S_SV_WAIT;
					end
				end
				S_SAVE: begin
					if (x_done_q) begin
						saved_q <= rd_q;
						st_q <= S_FS;
					end
				end
				S_FS: begin
					if (x_done_q) begin
						st_q <= S_PU_DP;
					end
				end
				S_PU_DP: begin
					if (x_done_q) begin
						st_q <= S_PU_DM;
					end
				end
				S_PU_DM: begin
					if (x_done_q) begin
						st_q <= S_LINE;
					end
				end
				S_LINE: begin
					if (x_done_q) begin
						line_q <= rd_q[1:0];
						if (rd_q[1:0] == `UCDS_LS_SE1) begin
							res_q <= `UCDS_RES_CHARGER;
						end else if (rd_q[1:0] == `UCDS_LS_SE0) begin
							res_q <= `UCDS_RES_HOST;
						end else begin
							res_q <= `UCDS_RES_UNDET;
						end
						st_q <= S_CLR_PU;
					end
				end
				S_CLR_PU: begin
					if (x_done_q) begin
						st_q <= S_RESTORE;
					end
				end
				S_RESTORE: begin
					if (x_done_q) begin
						st_q <= S_DONE;
					end
				end
				S_DONE: begin
					busy_q <= 1'b0;
					ev_q[`UCDS_IRQ_DONE] <= 1'b1;
					ev_q[`UCDS_IRQ_CHARGER] <= (res_q == `UCDS_RES_CHARGER);
					ev_q[`UCDS_IRQ_HOST] <= (res_q == `UCDS_RES_HOST);
					ev_q[`UCDS_IRQ_UNDET] <= (res_q == `UCDS_RES_UNDET);
					st_q <= S_IDLE;
				end
				default: st_q <= S_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Wishbone slave, control and interrupt registers
	// ----------------------------------------------------------------
	// Ack one cycle after the strobe and drop it the next, so every
	// access takes exactly one wait state; unmapped reads return zero.
	assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wb_wr = wb_req & wb_we_i & wb_sel_i[0];

	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
			ctrl_q <= 3'h0;
			start_q <= 1'b0;
			irq_stat_q <= 4'h0;
			irq_en_q <= 4'h0;
			irq <= 1'b0;
		end else begin
			wb_ack_o <= wb_req;
			start_q <= wb_wr && wb_adr_i == `UCDS_A_CTRL && wb_dat_i[`UCDS_CTRL_START] && !busy_q;
			if (wb_wr && wb_adr_i == `UCDS_A_CTRL) begin
				ctrl_q <= wb_dat_i[2:0];
			end
			if (wb_wr && wb_adr_i == `UCDS_A_IRQ_EN) begin
				irq_en_q <= wb_dat_i[3:0];
			end
			// New events win over a clear in the same cycle
			if (wb_wr && wb_adr_i == `UCDS_A_IRQ_CLR) begin
				irq_stat_q <= (irq_stat_q & ~wb_dat_i[3:0]) | ev_q;
			end else begin
				irq_stat_q <= irq_stat_q | ev_q;
			end
			irq <= |(irq_stat_q & irq_en_q);
			if (wb_req && !wb_we_i) begin
				case (wb_adr_i)
					`UCDS_A_CTRL: wb_dat_o <= {29'h0, ctrl_q[2:1], 1'b0}; // Start reads 0
					`UCDS_A_STATUS: wb_dat_o <= {19'h0, live_ls_q, nsync_q, 1'b0, line_q,
						rid_ok_q, rcode_q, res_q, busy_q};
					`UCDS_A_IRQ_STAT: wb_dat_o <= {28'h0, irq_stat_q};
					`UCDS_A_IRQ_EN: wb_dat_o <= {28'h0, irq_en_q};
					default: wb_dat_o <= 32'h00000000;
				endcase
			end else begin
				wb_dat_o <= 32'h00000000;
			end
		end
	end

endmodule
`default_nettype wire

// File: tb/ucds_phy_model.sv
// ULPI PHY model: clock source, register file, line and session levels.
// Assumes the link holds each byte until nxt and ends a write with stp.
`timescale 1ns/100ps
`default_nettype none
module ucds_phy_model (
	// Link drive
	input wire logic [7:0] ulpi_data_o,
	input wire logic ulpi_data_oe,
	input wire logic ulpi_stp,
	// PHY drive and resolved bus
	output logic ulpi_clk,
	output logic ulpi_dir,
	output logic ulpi_nxt,
	output logic [7:0] ulpi_wire
);
	logic [7:0] regs [0:63];
	logic [7:0] pd, wd, rx_last;
	logic [5:0] ad, b;
	logic [1:0] attach, ls;
	logic [2:0] rid_code;
	logic sess, lowpwr, lp_int, id_grounded_flag;
	int st, slow, wait_n, conv_n;
	// Triples of write, set and clear addresses share one register
	function automatic [5:0] base(input logic [5:0] a);
		base = a >= 6'h39 ? 6'h39 : a >= 6'h36 ? 6'h36 : (a >= 6'h0a && a <= 6'h0c) ? 6'h0a :
			(a >= 6'h04 && a <= 6'h06) ? 6'h04 : a;
	endfunction
	// Shorted lines show SE1 only once non-driving FS and both pull-ups are set
	assign ls = attach == 2'h1 ? ((regs[6'h04] == 8'h49 && regs[6'h39][5:4] == 2'h3) ?
		2'h3 : 2'h2) : attach == 2'h0 ? 2'h0 : 2'h1;
	// Released bus shows the inverse of the PHY byte, never a stale copy
	assign ulpi_wire = ulpi_dir ? pd : ulpi_data_oe ? ulpi_data_o : ~pd;
	initial begin
		for (int i = 0; i < 64; i++) regs[i] = 8'h00;
		regs[6'h04] = 8'h41;
		{ulpi_clk, ulpi_dir, ulpi_nxt, pd, rx_last} = '0;
		{attach, rid_code, sess, lowpwr, lp_int, id_grounded_flag} = '0;
		{st, slow, wait_n, conv_n} = '0;
		#37;
		forever #80 ulpi_clk = ~ulpi_clk;
	end
	// ----------------------------------------------------------------
	// Register file and bus
	// ----------------------------------------------------------------
	always @(posedge ulpi_clk) begin
		if (regs[6'h36][4] && conv_n < 6) conv_n++;
		else if (regs[6'h36][4]) begin
			conv_n = 0;
			regs[6'h36][4:0] = {2'h1, regs[6'h0a][0] ? rid_code : 3'h7};
		end
		case (st)
		0: if (lowpwr) begin
			ulpi_dir <= 1'b1;
			pd <= {4'h0, lp_int, 1'b0, ls};
			if (ulpi_stp) begin
				lowpwr = 1'b0;
				ulpi_dir <= 1'b0;
			end
		end else if (ulpi_data_oe && ulpi_data_o[7]) begin
			// Slow mode holds off nxt on a command byte
			if (wait_n < slow) wait_n++;
			else begin
				wait_n = 0;
				ad = ulpi_data_o[5:0];
				ulpi_nxt <= 1'b1;
				st = ulpi_data_o[6] ? 3 : 1;
			end
		end else if ({sess, ls} != {rx_last[3], rx_last[1:0]}) begin
			ulpi_dir <= 1'b1;
			st = 5;
		end
		1: if (ulpi_stp) begin
			b = base(ad);
			case (ad - b)
			6'h0: regs[b] = wd;
			6'h1: regs[b] = regs[b] | wd;
			6'h2: regs[b] = regs[b] & ~wd;
			default: ;
			endcase
			ulpi_nxt <= 1'b0;
			st = 0;
		end else wd = ulpi_data_o;
		3: begin
			ulpi_nxt <= 1'b0;
			ulpi_dir <= 1'b1;
			st = 4;
		end
		4: begin
			b = base(ad);
			pd <= ad == 6'h13 ? {3'h0, id_grounded_flag, 1'b0, sess, 2'h0} : ad == 6'h15 ? {6'h0, ls} : regs[b];
			if (b == 6'h36) regs[b][3] = 1'b0;
			st = 6;
		end
		5: begin
			rx_last = {4'h0, sess, 1'b0, ls};
			pd <= rx_last;
			st = 6;
		end
		default: begin
			ulpi_dir <= 1'b0;
			st = 0;
		end
		endcase
	end
endmodule
`default_nettype wire

// File: tb/ucds_chk.sv
// Checker for the sequencer top: bus handshake, irq mask, ULPI drive.
// Assumes a single clk_sys domain reset by arst_n.
`timescale 1ns/100ps
`default_nettype none
module ucds_chk (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// Wishbone and interrupt
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic irq,
	// ULPI
	input wire logic ulpi_clk,
	input wire logic ulpi_dir,
	input wire logic [7:0] ulpi_data_o,
	input wire logic ulpi_data_oe,
	input wire logic ulpi_stp
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	logic clk_d_q;
	logic [3:0] since_q;
	// Cycles since the raw ULPI clock rose, saturating
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			clk_d_q <= 1'b0;
			since_q <= 4'hf;
		end else begin
			clk_d_q <= ulpi_clk;
			since_q <= (ulpi_clk && !clk_d_q) ? 4'h0 : since_q + {3'h0, since_q != 4'hf};
		end
	end
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing after request");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
	a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data outside ack");
	a_irq_mask: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0] &&
		wb_adr_i == 8'h10 && wb_dat_i[3:0] == 4'h0 |-> ##[1:4] !irq) else $error("irq not masked");
	a_no_drive_dir: assert property (ulpi_dir [*4] |-> !ulpi_data_oe)
		else $error("link drives while PHY owns bus");
	a_stp_frame: assert property ($rose(ulpi_stp) && ulpi_data_oe |->
		(ulpi_stp && ulpi_data_o == 8'h00) [*8] ##1 !ulpi_stp)
		else $error("stop not one ULPI clock with zero data");
	a_edge_timed: assert property ($changed(ulpi_data_o) || $changed(ulpi_stp) |->
		since_q >= 4'h1 && since_q <= 4'h6) else $error("ULPI drive off clock edge");
	a_rst_quiet: assert property ($rose(arst_n) |-> !ulpi_stp && !ulpi_data_oe && !wb_ack_o)
		else $error("outputs active at reset release");
	c_irq: cover property ($rose(irq));
	c_write_end: cover property ($rose(ulpi_stp) && ulpi_data_oe);
	c_wake: cover property (ulpi_dir && ulpi_stp);
endmodule
bind ucds_top ucds_chk chk_u (.clk_sys(clk_sys), .arst_n(arst_n), .wb_adr_i(wb_adr_i),
	.wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq),
	.ulpi_clk(ulpi_clk), .ulpi_dir(ulpi_dir), .ulpi_data_o(ulpi_data_o),
	.ulpi_data_oe(ulpi_data_oe), .ulpi_stp(ulpi_stp));
`default_nettype wire

// File: tb/tb.sv
// Testbench: sequencer against the PHY model, driven over Wishbone.
// Assumes the model owns the ULPI side and the checker is bound.
`timescale 1ns/100ps
`default_nettype none
`include "ucds_consts.vh"
module tb;
	logic clk_sys, arst_n, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, irq;
	logic ulpi_clk, ulpi_dir, ulpi_nxt, ulpi_data_oe, ulpi_stp;
	logic [7:0] wb_adr_i, ulpi_data_o, wire_d;
	logic [31:0] wb_dat_i, wb_dat_o, s;
	logic [3:0] wb_sel_i;
	int fail_count, cmp_count;
	ucds_top dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
		.wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq), .ulpi_clk(ulpi_clk),
		.ulpi_dir(ulpi_dir), .ulpi_nxt(ulpi_nxt), .ulpi_data_i(wire_d), .ulpi_data_o(ulpi_data_o),
		.ulpi_data_oe(ulpi_data_oe), .ulpi_stp(ulpi_stp));
	ucds_phy_model phy_u (.ulpi_data_o(ulpi_data_o), .ulpi_data_oe(ulpi_data_oe),
		.ulpi_stp(ulpi_stp), .ulpi_clk(ulpi_clk), .ulpi_dir(ulpi_dir), .ulpi_nxt(ulpi_nxt),
		.ulpi_wire(wire_d));
	// 50 MHz system clock
	always #10 clk_sys = ~clk_sys;
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Classic cycle, held until ack; a lost ack counts as a mismatch
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hf;
		do begin
			@(posedge clk_sys);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		s = wb_dat_o;
		chk(32'(n < 50), 32'h1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_sys);
	endtask
	// Poll status until idle, bounded
	task automatic poll();
		int n;
		n = 0;
		do begin
			repeat (100) @(posedge clk_sys);
			wb(1'b0, `UCDS_A_STATUS, 32'h0);
			n++;
		end while (s[0] !== 1'b0 && n < 200);
	endtask
	// One run: partner set-up, start, wait, result and interrupt status
	task automatic run(input logic [2:0] ctl, input logic [1:0] att, input logic [1:0] res,
		input logic [3:0] ev);
		phy_u.attach = att;
		wb(1'b1, `UCDS_A_CTRL, {29'h0, ctl});
		poll();
		chk(32'(s[2:1]), 32'(res));
		chk(32'(phy_u.regs[6'h39][5:4]), 32'h0);
		chk(32'(phy_u.regs[6'h04]), 32'h41);
		wb(1'b0, `UCDS_A_IRQ_STAT, 32'h0);
		chk(s, 32'(ev));
		wb(1'b1, `UCDS_A_IRQ_CLR, 32'hf);
	endtask
	task give_verdict;
		$display("TB: compares=%0d mismatches=%0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Watchdog well beyond the expected run length
	initial begin
		#1500000;
		fail_count++;
		give_verdict();
	end
	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		{clk_sys, arst_n, wb_we_i, wb_cyc_i, wb_stb_i, wb_adr_i, wb_dat_i, wb_sel_i} = '0;
		{fail_count, cmp_count} = '0;
		repeat (16) @(posedge clk_sys);
		arst_n <= 1'b1;
		@(posedge clk_sys);
		// Read-only and unmapped writes first, then control, status, interrupt status and enable registers still read their reset zero
		wb(1'b1, `UCDS_A_STATUS, 32'h1ffe);
		wb(1'b1, 8'hfc, 32'h7);
		for (int i = 0; i < 5; i += (i == 2) ? 2 : 1) begin
			wb(1'b0, 8'(i * 4), 32'h0);
			chk(s, 32'h0);
		end
		wb(1'b1, `UCDS_A_IRQ_EN, 32'hf);
		wb(1'b0, `UCDS_A_IRQ_EN, 32'h0);
		chk(s, 32'hf);
		// Charger with resistance check first; interrupt stays up until cleared
		phy_u.id_grounded_flag = 1'b1;
		phy_u.sess = 1'b1;
		phy_u.rid_code = 3'h2;
		phy_u.attach = 2'h1;
		wb(1'b1, `UCDS_A_CTRL, 32'h3);
		poll();
		chk(32'(s[6:3]), 32'ha);
		wb(1'b0, `UCDS_A_CTRL, 32'h0);
		chk(s, 32'h2);
		chk(32'(phy_u.regs[6'h36][3]), 32'h0);
		chk(32'(phy_u.regs[6'h0a][0]), 32'h1);
		chk(32'(irq), 32'h1);
		run(3'h1, 2'h1, `UCDS_RES_CHARGER, 4'h3);
		chk(32'(irq), 32'h0);
		// Host behind a slow PHY; no session yet, so the run must wait
		phy_u.slow = 3;
		phy_u.sess = 1'b0;
		phy_u.attach = 2'h0;
		// Let the session-lost RXCMD land first, or the stale session bit lets it run
		repeat (50) @(posedge clk_sys);
		wb(1'b1, `UCDS_A_CTRL, 32'h1);
		repeat (600) @(posedge clk_sys);
		wb(1'b0, `UCDS_A_STATUS, 32'h0);
		chk(32'(s[2:0]), 32'h1);
		phy_u.sess = 1'b1;
		poll();
		chk(32'(s[2:1]), 32'(`UCDS_RES_HOST));
		wb(1'b1, `UCDS_A_IRQ_EN, 32'h0);
		repeat (3) @(posedge clk_sys);
		chk(32'(irq), 32'h0);
		wb(1'b1, `UCDS_A_IRQ_EN, 32'hf);
		phy_u.slow = 0;
		// Host bits were never cleared, so they are still pending beside the new ones
		run(3'h1, 2'h2, `UCDS_RES_UNDET, 4'hd);
		// Low power: line state seen on data[1:0], wake on data[3] interrupt
		phy_u.sess = 1'b0;
		phy_u.lowpwr = 1'b1;
		phy_u.attach = 2'h1;
		repeat (50) @(posedge clk_sys);
		wb(1'b1, `UCDS_A_CTRL, 32'h5);
		repeat (300) @(posedge clk_sys);
		wb(1'b0, `UCDS_A_STATUS, 32'h0);
		chk(32'({s[12:10], s[0]}), 32'hb);
		wb(1'b0, `UCDS_A_CTRL, 32'h0);
		chk(s, 32'h4);
		phy_u.sess = 1'b1;
		phy_u.lp_int = 1'b1;
		run(3'h0, 2'h1, `UCDS_RES_CHARGER, 4'h3);
		chk(32'(phy_u.lowpwr), 32'h0);
		give_verdict();
	end
endmodule
`default_nettype wire
